// File: hw/rsf_map.svh
// offsets, field positions, reset values and timing counts of the sequencer
`ifndef RSF_MAP_SVH
`define RSF_MAP_SVH
`define RSF_CTRL_OFS 8'h00
`define RSF_STAT_OFS 8'h04
`define RSF_SSREF_OFS 8'h08
`define RSF_CTRL_SHDN_BIT 0
`define RSF_CTRL_RST 32'h0000_0000
`define RSF_STAT_PG_BIT 4
`define RSF_STAT_OVL_BIT 5
`define RSF_STAT_OT_BIT 6
`define RSF_STAT_HOLD_BIT 7
`define RSF_START_DLY 384
`define RSF_CH_OC_BLANK 7
`define RSF_HICCUP_SS 3
`define RSF_PG_FILT 3
`define RSF_CLK_NS 5
`define RSF_GATE_OFF_NS 100
`define RSF_GATE_OFF_CYC (`RSF_GATE_OFF_NS / `RSF_CLK_NS)
`endif

// File: hw/rsf_pkg.sv
// types of the regulator start-up and fault sequencer
package rsf_pkg;
    typedef enum logic [2:0] {
        RSF_WAIT_EN = 3'b000,
        RSF_DELAY = 3'b001,
        RSF_SOFT = 3'b010,
        RSF_REG = 3'b011,
        RSF_HICCUP = 3'b100,
        RSF_OV_LATCH = 3'b101
    } rsf_state_type;
endpackage

// File: hw/rsf_sequencer.sv
// start-up, soft-start, power-good and fault sequencer with apb registers
//
// Functional notes
// R01: start soft-start 384 switching cycles after enable, supplies and pll are good
// R02: sink enable hysteresis current only while not yet enabled
// R03: supply loss, shutdown or fault resets soft-start and stops gates within 100ns
// R04: ramp amplitude follows 1.25x feed-forward once enabled
// R05: outside circuit keeps feed-forward above 0.7V before and during switching
// R06: any internal fault pulls the shared enable line low
// R07: outside pull-up limits fault sink to 5mA; never tie enable to supply
// R08: soft-start reference counts up one step per phase clock pulse
// R09: gates wait for first pwm pulse; low side held on first cycle
// R10: output above target below 113%: no switching until target and pwm pulse
// R11: pre-charge 113-120%: hold enable low, low side on 113 off 87
// R12: pre-charge above 120% latches off, no power-up
// R13: power-good only after soft-start; drops on disable or window fault
// R14: power-good drops only after three consecutive window fault cycles
// R15: undervoltage counted after soft-start, not during ov, oc, ot, pll faults
// R16: above 120% from soft-start: latch high side off, low side till 87%
// R17: overvoltage latch clears only on bias supply removal
// R18: enable low and above 113%: low side on until below 87%
// R19: over 150C pull enable low, release below 125C
// R20: share-bus overcurrent compare active from start-up
// R21: channel overcurrent compare waits 7 switching cycles
// R22: share and local nodes source average current plus offset
// R23: overcurrent trip pulls enable low, both gates off
// R24: after overcurrent wait three soft-start intervals then retry
// R25: wait enable, delay, soft-start, regulate; faults return to wait
//
// Implementation choices: the APB register port and the address map.
`timescale 1ns/1ps
`include "rsf_map.svh"

module rsf_sequencer #(
    parameter int SS_STEPS = 1024,
    parameter int CW = 16
) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic reset_n,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // shared enable line, open drain
    input wire logic en_line_in,
    output logic en_line_out,
    output logic en_line_oe,
    // supply, clock and modulator status
    input wire logic bias_por_ok,
    input wire logic pll_locked,
    input wire logic phase_clk_pulse,
    input wire logic pwm_pulse,
    // output monitor comparators
    input wire logic out_above_target,
    input wire logic out_above_113,
    input wire logic out_above_120,
    input wire logic out_below_87,
    input wire logic out_below_uv,
    input wire logic out_in_window,
    // temperature and current comparators
    input wire logic temp_above_150,
    input wire logic temp_below_125,
    input wire logic share_bus_oc,
    input wire logic channel_oc,
    // drives and flags
    output logic high_side_drive,
    output logic low_side_drive,
    output logic power_good_flag,
    output logic en_sink_on,
    output logic ramp_feedforward_on,
    output logic share_source_on,
    output logic [CW-1:0] ss_ref
);
    import rsf_pkg::*;

    localparam int GOFF = `RSF_GATE_OFF_CYC;
    localparam logic [CW-1:0] DLY_LAST = CW'(`RSF_START_DLY - 1);
    localparam logic [CW-1:0] SS_LAST = CW'(SS_STEPS - 1);
    localparam logic [CW-1:0] HIC_LAST = CW'(`RSF_HICCUP_SS * SS_STEPS - 1);

    rsf_state_type state_q, state_d;
    logic [CW-1:0] cnt_q, cnt_d, ss_ref_q;
    logic [2:0] blank_q;
    logic [1:0] flt_cnt_q, flt_cnt_d;
    logic shdn_q, ot_q, prechg_q, lo_clamp_q, ov_ls_q;
    logic boot_done_q, sw_ok_q, hs_q, ls_q, pg_q, oe_q;
    logic sink_q, ramp_q, share_q, pready_q, pslverr_q;
    logic [31:0] prdata_q;
    logic en_ok, active, oc_trip, stop, flt, fault_pull;

    // ------------------------------------------------------------
    // fault terms
    // ------------------------------------------------------------
    assign en_ok = en_line_in & bias_por_ok & pll_locked & ~shdn_q;
    assign active = (state_q == RSF_SOFT) || (state_q == RSF_REG);
    // R20: share compare live; R21: channel compare after blanking
    assign oc_trip = active & (share_bus_oc | (channel_oc & (blank_q == 3'(`RSF_CH_OC_BLANK))));
    // R03: shutdown and faults stop the gates
    assign stop = ~en_ok | oc_trip | out_above_120;
    // R15: uv ignored while ov, oc, ot or pll faults stand
    assign flt = ~out_in_window
        | (out_below_uv & ~(out_above_113 | oc_trip | ot_q | ~pll_locked));
    // R06: faults pull the shared line
    assign fault_pull = ot_q | prechg_q | oc_trip | (state_d == RSF_HICCUP)
        | (state_d == RSF_OV_LATCH);

    // ------------------------------------------------------------
    // sequencer
    // ------------------------------------------------------------
    // R25: wait, delay, soft-start, regulate
    always_comb begin
        state_d = state_q;
        cnt_d = cnt_q;
        case (state_q)
            RSF_WAIT_EN: begin
                cnt_d = '0;
                // R12: pre-charge over 120% latches
                if (out_above_120 && bias_por_ok) begin
                    state_d = RSF_OV_LATCH;
                end else if (en_ok && !prechg_q) begin
                    state_d = RSF_DELAY;
                end
            end
            RSF_DELAY: begin
                if (out_above_120) begin
                    state_d = RSF_OV_LATCH;
                end else if (!en_ok) begin
                    state_d = RSF_WAIT_EN;
                end else if (phase_clk_pulse) begin
                    // R01: 384 switching cycles before soft-start
                    if (cnt_q == DLY_LAST) begin
                        state_d = RSF_SOFT;
                        cnt_d = '0;
                    end else begin
                        cnt_d = cnt_q + 1'b1;
                    end
                end
            end
            RSF_SOFT, RSF_REG: begin
                // R16: overvoltage latch from soft-start on
                if (out_above_120) begin
                    state_d = RSF_OV_LATCH;
                // R23: overcurrent enters hiccup
                end else if (oc_trip) begin
                    state_d = RSF_HICCUP;
                    cnt_d = '0;
                end else if (!en_ok) begin
                    state_d = RSF_WAIT_EN;
                end else if (state_q == RSF_SOFT && phase_clk_pulse && ss_ref_q == SS_LAST) begin
                    state_d = RSF_REG;
                end
            end
            RSF_HICCUP: begin
                // R24: three soft-start intervals, then retry
                if (!bias_por_ok) begin
                    state_d = RSF_WAIT_EN;
                end else if (phase_clk_pulse) begin
                    if (cnt_q == HIC_LAST) begin
                        state_d = RSF_WAIT_EN;
                    end else begin
                        cnt_d = cnt_q + 1'b1;
                    end
                end
            end
            RSF_OV_LATCH: begin
                // R17: only bias removal releases the latch
                if (!bias_por_ok) begin
                    state_d = RSF_WAIT_EN;
                end
            end
            default: begin
                state_d = RSF_WAIT_EN;
            end
        endcase
    end

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            state_q <= RSF_WAIT_EN;
            cnt_q <= '0;
        end else begin
            state_q <= state_d;
            cnt_q <= cnt_d;
        end
    end

    // R08: soft-start reference, one step per phase pulse
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            ss_ref_q <= '0;
        end else if (state_d != RSF_SOFT && state_d != RSF_REG) begin
            ss_ref_q <= '0;
        end else if (state_q == RSF_SOFT && state_d == RSF_SOFT && phase_clk_pulse) begin
            ss_ref_q <= ss_ref_q + 1'b1;
        end
    end

    // R21: channel compare blanking in switching cycles
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            blank_q <= '0;
        end else if (!active) begin
            blank_q <= '0;
        end else if (phase_clk_pulse && blank_q != 3'(`RSF_CH_OC_BLANK)) begin
            blank_q <= blank_q + 1'b1;
        end
    end

    // ------------------------------------------------------------
    // protection flags
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            ot_q <= 1'b0;
            prechg_q <= 1'b0;
            lo_clamp_q <= 1'b0;
            ov_ls_q <= 1'b0;
        end else begin
            // R19: temperature hysteresis
            if (temp_above_150) begin
                ot_q <= 1'b1;
            end else if (temp_below_125) begin
                ot_q <= 1'b0;
            end
            // R11: pre-charge hold before switching
            if ((state_q == RSF_WAIT_EN || state_q == RSF_DELAY)
                && out_above_113 && !out_above_120) begin
                prechg_q <= 1'b1;
            end else if (out_below_87 || state_q == RSF_OV_LATCH) begin
                prechg_q <= 1'b0;
            end
            // R18: low-side clamp set while enable low above 113%, held until below 87%
            if (!en_line_in && out_above_113) begin
                lo_clamp_q <= 1'b1;
            end else if (out_below_87) begin
                lo_clamp_q <= 1'b0;
            end
            // R16: low side on at trip, off for good below 87%
            if (state_q != RSF_OV_LATCH && state_d == RSF_OV_LATCH) begin
                ov_ls_q <= 1'b1;
            end else if (out_below_87 || !bias_por_ok) begin
                ov_ls_q <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------
    // gate drives
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            boot_done_q <= 1'b0;
            sw_ok_q <= 1'b0;
            hs_q <= 1'b0;
            ls_q <= 1'b0;
        end else begin
            if (state_q != RSF_SOFT && state_q != RSF_REG) begin
                boot_done_q <= 1'b0;
                sw_ok_q <= 1'b0;
            end else begin
                // R09: bootstrap charge over first cycle
                if (phase_clk_pulse) begin
                    boot_done_q <= 1'b1;
                end
                // R10: wait for target and a pwm pulse
                if (boot_done_q && pwm_pulse && !out_above_target) begin
                    sw_ok_q <= 1'b1;
                end
            end
            // R03: stop both gates at once
            if (!bias_por_ok) begin
                hs_q <= 1'b0;
                ls_q <= 1'b0;
            end else if (state_d == RSF_OV_LATCH) begin
                hs_q <= 1'b0;
                ls_q <= (state_q != RSF_OV_LATCH) || (ov_ls_q && !out_below_87);
            end else if (stop || !active) begin
                hs_q <= 1'b0;
                // R18: clamp low side once line is low above 113%, until below 87%
                ls_q <= (lo_clamp_q || (!en_line_in && out_above_113)) && !out_below_87;
            end else if (!boot_done_q) begin
                hs_q <= 1'b0;
                ls_q <= 1'b1;
            end else if (sw_ok_q) begin
                hs_q <= pwm_pulse;
                ls_q <= !pwm_pulse;
            end else begin
                hs_q <= 1'b0;
                ls_q <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------
    // power-good and pin flags
    // ------------------------------------------------------------
    // R14: three consecutive fault cycles
    always_comb begin
        flt_cnt_d = 2'd0;
        if (state_d == RSF_REG && flt) begin
            flt_cnt_d = (flt_cnt_q == 2'(`RSF_PG_FILT)) ? flt_cnt_q : flt_cnt_q + 1'b1;
        end
    end

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            flt_cnt_q <= '0;
            pg_q <= 1'b0;
            oe_q <= 1'b0;
            sink_q <= 1'b0;
            ramp_q <= 1'b0;
            share_q <= 1'b0;
        end else begin
            flt_cnt_q <= flt_cnt_d;
            // R13: only in regulation, dropped by filtered fault
            pg_q <= (state_d == RSF_REG) && (flt_cnt_d != 2'(`RSF_PG_FILT));
            // R06: pull shared line on internal fault
            oe_q <= fault_pull;
            // R02: hysteresis sink until enabled
            sink_q <= (state_d == RSF_WAIT_EN);
            // R04: feed-forward ramp scaling once enabled
            ramp_q <= (state_d == RSF_DELAY) || (state_d == RSF_SOFT) || (state_d == RSF_REG);
            // R22: current copies while biased
            share_q <= bias_por_ok;
        end
    end

    // ------------------------------------------------------------
    // apb registers
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            shdn_q <= 1'(`RSF_CTRL_RST >> `RSF_CTRL_SHDN_BIT);
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q <= '0;
        end else begin
            pready_q <= psel && !penable;
            if (psel && !penable) begin
                pslverr_q <= !(paddr == `RSF_CTRL_OFS || paddr == `RSF_STAT_OFS
                    || paddr == `RSF_SSREF_OFS);
                prdata_q <= '0;
                if (!pwrite) begin
                    case (paddr)
                        `RSF_CTRL_OFS: prdata_q[`RSF_CTRL_SHDN_BIT] <= shdn_q;
                        `RSF_STAT_OFS: begin
                            prdata_q[2:0] <= state_q;
                            prdata_q[`RSF_STAT_PG_BIT] <= pg_q;
                            prdata_q[`RSF_STAT_OVL_BIT] <= (state_q == RSF_OV_LATCH);
                            prdata_q[`RSF_STAT_OT_BIT] <= ot_q;
                            prdata_q[`RSF_STAT_HOLD_BIT] <= prechg_q;
                        end
                        `RSF_SSREF_OFS: prdata_q[CW-1:0] <= ss_ref_q;
                        default: prdata_q <= '0;
                    endcase
                end
            end
            if (psel && penable && pready_q && pwrite && paddr == `RSF_CTRL_OFS) begin
                shdn_q <= pwdata[`RSF_CTRL_SHDN_BIT];
            end
        end
    end

    assign prdata = prdata_q;
    assign pready = pready_q;
    assign pslverr = pslverr_q;
    assign en_line_out = 1'b0;
    assign en_line_oe = oe_q;
    assign high_side_drive = hs_q;
    assign low_side_drive = ls_q;
    assign power_good_flag = pg_q;
    assign en_sink_on = sink_q;
    assign ramp_feedforward_on = ramp_q;
    assign share_source_on = share_q;
    assign ss_ref = ss_ref_q;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!reset_n);

    sequence s_delay_end;
        state_q == RSF_DELAY && phase_clk_pulse && cnt_q == DLY_LAST && en_ok && !out_above_120;
    endsequence
    sequence s_flt3;
        (pg_q && flt && state_d == RSF_REG) ##1 (flt && state_d == RSF_REG) [*2];
    endsequence

    chk_start_delay: assert property (s_delay_end |=> state_q == RSF_SOFT) // R01
        else $error("soft-start not entered after start delay");
    chk_gate_stop: assert property (!bias_por_ok |-> ##[1:GOFF] (!hs_q && !ls_q)) // R03
        else $error("gates still driven after supply loss");
    chk_oc_pull: assert property (oc_trip && !out_above_120
        |=> (oe_q && !hs_q && state_q == RSF_HICCUP)) // R23
        else $error("overcurrent did not pull enable low");
    chk_ot_pull: assert property ($rose(ot_q) |=> oe_q ##1 oe_q) // R19
        else $error("overtemperature did not hold enable low");
    chk_pg_filter: assert property (s_flt3 |=> !pg_q) // R14
        else $error("power-good not dropped after three fault cycles");
    chk_pg_single: assert property (pg_q && flt && state_d == RSF_REG
        && flt_cnt_q < 2'(`RSF_PG_FILT - 1) ##1 !flt |-> pg_q) // R14
        else $error("power-good dropped on a short fault");
    chk_pg_reg: assert property (pg_q |-> state_q == RSF_REG) // R13
        else $error("power-good outside regulation");
    chk_ov_hold: assert property (state_q == RSF_OV_LATCH && bias_por_ok
        |=> state_q == RSF_OV_LATCH && !hs_q && oe_q && !pg_q) // R17
        else $error("overvoltage latch released without bias loss");
    chk_no_early_hs: assert property (active && !sw_ok_q |=> !hs_q) // R09
        else $error("high side driven before first pwm pulse");
    chk_ss_step: assert property (state_q == RSF_SOFT && state_d == RSF_SOFT && phase_clk_pulse
        |=> ss_ref_q == $past(ss_ref_q) + 1'b1) // R08
        else $error("soft-start reference did not step");
    chk_sink_off: assert property (state_d == RSF_DELAY |=> !sink_q) // R02
        else $error("hysteresis sink left on after enable");

endmodule // rsf_sequencer

// File: tb/rsf_peer_model.sv
// peer module sharing the open-drain enable line
`timescale 1ns/1ps

module rsf_peer_model (
    // clock and reset
    input wire logic clk_sys,
    input wire logic reset_n,
    // peer fault request and device pull
    input wire logic peer_fault,
    input wire logic dut_oe,
    input wire logic dut_out,
    // resolved line level
    output logic en_line
);
    logic pull_q;

    // peer fault pulls the line low
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            pull_q <= 1'h1;
        end else begin
            pull_q <= peer_fault;
        end
    end

    // resistor pull-up, never tied to the supply
    assign en_line = (pull_q || (dut_oe && !dut_out)) ? 1'h0 : 1'h1;
endmodule // rsf_peer_model

// File: tb/rsf_sequencer_tb.sv
// self-checking bench of the start-up and fault sequencer
`timescale 1ns/1ps
`include "rsf_map.svh"

module rsf_sequencer_tb;
    import rsf_pkg::*;
    logic clk_sys = 1'h0, reset_n = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic pready, pslverr, err_flag, en_line, en_line_out, en_line_oe;
    logic bias_por_ok = 1'h0, pll_locked = 1'h0, phase_clk_pulse = 1'h0, pwm_pulse = 1'h0;
    logic out_above_target = 1'h0, out_above_113 = 1'h0, out_above_120 = 1'h0;
    logic out_below_87 = 1'h0, out_below_uv = 1'h0, out_in_window = 1'h1;
    logic temp_above_150 = 1'h0, temp_below_125 = 1'h1, share_bus_oc = 1'h0;
    logic channel_oc = 1'h0, peer_fault = 1'h1, hs, ls, pg, sink, ffon, srcon;
    logic [15:0] ss_ref;
    int err_count = 0, compares = 0, cycles = 0;

    initial begin
        forever #2.5 clk_sys = ~clk_sys;
    end

    rsf_sequencer #(.SS_STEPS(8)) rsf_sequencer_inst (.clk_sys(clk_sys), .reset_n(reset_n),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .en_line_in(en_line),
        .en_line_out(en_line_out), .en_line_oe(en_line_oe), .bias_por_ok(bias_por_ok),
        .pll_locked(pll_locked), .phase_clk_pulse(phase_clk_pulse), .pwm_pulse(pwm_pulse),
        .out_above_target(out_above_target), .out_above_113(out_above_113),
        .out_above_120(out_above_120), .out_below_87(out_below_87),
        .out_below_uv(out_below_uv), .out_in_window(out_in_window),
        .temp_above_150(temp_above_150), .temp_below_125(temp_below_125),
        .share_bus_oc(share_bus_oc), .channel_oc(channel_oc), .high_side_drive(hs),
        .low_side_drive(ls), .power_good_flag(pg), .en_sink_on(sink),
        .ramp_feedforward_on(ffon), .share_source_on(srcon), .ss_ref(ss_ref));

    rsf_peer_model rsf_peer_model_inst (.clk_sys(clk_sys), .reset_n(reset_n),
        .peer_fault(peer_fault), .dut_oe(en_line_oe), .dut_out(en_line_out),
        .en_line(en_line));

    // ----------------------------------------
    // shared tasks
    // ----------------------------------------
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            err_count++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic settle(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask

    task automatic pulses(input int n);
        repeat (n) begin
            @(posedge clk_sys);
            phase_clk_pulse <= 1'h1;
            @(posedge clk_sys);
            phase_clk_pulse <= 1'h0;
        end
        settle(1);
    endtask

    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        @(posedge clk_sys);
        psel <= 1'h1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge clk_sys);
        penable <= 1'h1;
        do begin
            @(posedge clk_sys);
        end while (pready !== 1'h1);
        rd = prdata;
        err_flag = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
        #1;
    endtask

    task automatic rstat();
        apb(1'h0, `RSF_STAT_OFS, 32'h0);
    endtask

    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task automatic t_reset();
        settle(1);
        check({hs, ls, pg, sink, en_line_oe}, 32'h0);
        repeat (7) @(posedge clk_sys);
        reset_n <= 1'h1;
        settle(1);
        check(sink, 32'h1);
        apb(1'h0, `RSF_CTRL_OFS, 32'h0);
        check(rd, `RSF_CTRL_RST);
        rstat();
        check(rd[2:0], RSF_WAIT_EN);
        apb(1'h1, 8'h0C, 32'hFFFF_FFFF);
        check(err_flag, 32'h1);
    endtask

    task automatic bring_up();
        @(posedge clk_sys);
        peer_fault <= 1'h0;
        bias_por_ok <= 1'h1;
        pll_locked <= 1'h1;
        settle(2);
        check(sink, 32'h0);
        check(ffon, 32'h1);
        check(srcon, 32'h1);
        pulses(383);
        rstat();
        check(rd[2:0], RSF_DELAY);
        pulses(1);
        rstat();
        check(rd[2:0], RSF_SOFT);
        check({hs, ls}, 32'h1);
        check(ss_ref, 32'h0);
    endtask

    task automatic t_soft();
        @(posedge clk_sys);
        channel_oc <= 1'h1;
        pulses(1);
        check({hs, ls, ss_ref}, 32'h1);
        @(posedge clk_sys);
        pwm_pulse <= 1'h1;
        settle(2);
        check({hs, ls}, 32'h2);
        @(posedge clk_sys);
        pwm_pulse <= 1'h0;
        pulses(5);
        check(ss_ref, 32'h6);
        rstat();
        check(rd[2:0], RSF_SOFT);
        @(posedge clk_sys);
        channel_oc <= 1'h0;
        pulses(1);
        check(pg, 32'h0);
        pulses(1);
        check(pg, 32'h1);
        rstat();
        check(rd[2:0], RSF_REG);
    endtask

    task automatic t_pg();
        @(posedge clk_sys);
        out_in_window <= 1'h0;
        repeat (2) @(posedge clk_sys);
        out_in_window <= 1'h1;
        settle(2);
        check(pg, 32'h1);
        @(posedge clk_sys);
        out_in_window <= 1'h0;
        settle(2);
        check(pg, 32'h1);
        settle(1);
        check(pg, 32'h0);
        @(posedge clk_sys);
        out_in_window <= 1'h1;
        out_below_uv <= 1'h1;
        out_above_113 <= 1'h1;
        settle(6);
        check(pg, 32'h1);
        @(posedge clk_sys);
        out_above_113 <= 1'h0;
        settle(6);
        check(pg, 32'h0);
        @(posedge clk_sys);
        out_below_uv <= 1'h0;
        settle(6);
        check(pg, 32'h1);
    endtask

    task automatic t_stop();
        apb(1'h1, `RSF_CTRL_OFS, 32'h1);
        settle(`RSF_GATE_OFF_CYC);
        check({hs, ls, pg, ss_ref}, 32'h0);
        rstat();
        check(rd[2:0], RSF_WAIT_EN);
        apb(1'h1, `RSF_CTRL_OFS, 32'h0);
        settle(3);
        @(posedge clk_sys);
        peer_fault <= 1'h1;
        settle(3);
        check(sink, 32'h1);
        @(posedge clk_sys);
        peer_fault <= 1'h0;
        settle(3);
    endtask

    task automatic t_oc();
        @(posedge clk_sys);
        share_bus_oc <= 1'h1;
        settle(2);
        check({en_line_oe, hs, ls}, 32'h4);
        @(posedge clk_sys);
        share_bus_oc <= 1'h0;
        pulses(23);
        rstat();
        check(rd[2:0], RSF_HICCUP);
        pulses(1);
        settle(2);
        check(en_line_oe, 32'h0);
    endtask

    task automatic t_ot();
        @(posedge clk_sys);
        temp_above_150 <= 1'h1;
        temp_below_125 <= 1'h0;
        settle(3);
        rstat();
        check({en_line_oe, rd[`RSF_STAT_OT_BIT]}, 32'h3);
        @(posedge clk_sys);
        temp_above_150 <= 1'h0;
        settle(3);
        check(en_line_oe, 32'h1);
        @(posedge clk_sys);
        temp_below_125 <= 1'h1;
        settle(3);
        check(en_line_oe, 32'h0);
    endtask

    task automatic t_pre();
        @(posedge clk_sys);
        out_above_113 <= 1'h1;
        settle(3);
        check({en_line_oe, ls}, 32'h3);
        @(posedge clk_sys);
        out_above_113 <= 1'h0;
        out_below_87 <= 1'h1;
        settle(3);
        check({en_line_oe, ls}, 32'h0);
        @(posedge clk_sys);
        peer_fault <= 1'h1;
        out_below_87 <= 1'h0;
        out_above_113 <= 1'h1;
        settle(3);
        check(ls, 32'h1);
        @(posedge clk_sys);
        out_above_113 <= 1'h0;
        settle(3);
        check(ls, 32'h1);
        @(posedge clk_sys);
        out_below_87 <= 1'h1;
        settle(3);
        check(ls, 32'h0);
        @(posedge clk_sys);
        out_below_87 <= 1'h0;
    endtask

    task automatic t_ov();
        @(posedge clk_sys);
        out_above_120 <= 1'h1;
        settle(3);
        check({en_line_oe, pg, hs, ls}, 32'h9);
        @(posedge clk_sys);
        out_above_120 <= 1'h0;
        out_below_87 <= 1'h1;
        settle(3);
        check(ls, 32'h0);
        apb(1'h1, `RSF_CTRL_OFS, 32'h1);
        apb(1'h1, `RSF_CTRL_OFS, 32'h0);
        rstat();
        check({rd[`RSF_STAT_OVL_BIT], rd[2:0]}, {1'h1, RSF_OV_LATCH});
        @(posedge clk_sys);
        bias_por_ok <= 1'h0;
        settle(3);
        check(srcon, 32'h0);
        rstat();
        check(rd[2:0], RSF_WAIT_EN);
    endtask

    task automatic complete_run();
        $display("Comparisons %0d, mismatches %0d", compares, err_count);
        if (err_count == 0 && compares > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 8000) begin
            err_count++;
            complete_run();
        end
    end

    initial begin
        t_reset();
        bring_up();
        t_soft();
        t_pg();
        t_stop();
        bring_up();
        t_oc();
        t_ot();
        t_pre();
        bring_up();
        t_ov();
        complete_run();
    end
endmodule // rsf_sequencer_tb
